/* hdl/pin_select_defs.svh */
`ifndef PIN_SELECT_DEFS_SVH
`define PIN_SELECT_DEFS_SVH

// Selection codes for the general output pin
`define SEL_RX_OVERFLOW   6'h04
`define SEL_TX_UNDERFLOW  6'h05
`define SEL_PKT_FRAME     6'h06
`define SEL_CRC_PKT       6'h07
`define SEL_PREAMBLE_OK   6'h08
`define SEL_CLEAR_CHAN    6'h09
`define SEL_LOCK          6'h0a
`define SEL_SER_CLK       6'h0b
`define SEL_SER_SYNC_DATA 6'h0c
`define SEL_SER_ASYNC     6'h0d
`define SEL_CARRIER       6'h0e
`define SEL_CRC_OK        6'h0f
`define SEL_HARD_BIT1     6'h16
`define SEL_HARD_BIT0     6'h17
`define SEL_AMP_POWER     6'h1b

// Register file layout over APB
`define OFS_SEL    12'h000
`define OFS_STATUS 12'h004
`define OFS_MASK   12'h008
`define OFS_PQT    12'h00c
`define OFS_CCA    12'h010
`define OFS_LIVE   12'h014

// Field widths and reset values
`define PQ_W       4
`define SEL_RST    6'h00
`define PQT_RST    4'h0
`define CCA_RST    2'h0
`define EVT_N      5

// Status bit positions
`define EV_RXOVF   0
`define EV_TXUNF   1
`define EV_SYNC    2
`define EV_CRCGOOD 3
`define EV_LOCK    4

`endif

/* hdl/pin_select_pkg.sv */
package pin_select_pkg;
  // Radio status inputs after synchronising
  typedef struct packed {
    logic       rx_overflow;
    logic       tx_underflow;
    logic       rx_flush;
    logic       tx_flush;
    logic       sync_seen;
    logic       pkt_end;
    logic       addr_fail;
    logic       tx_mode;
    logic       crc_done;
    logic       crc_match;
    logic       rx_first_read;
    logic       rx_enter;
    logic [3:0] pq_level;
    logic       rssi_below;
    logic       rssi_above;
    logic       channel_busy_rx;
    logic       lock;
    logic       ser_clk;
    logic       ser_data;
    logic       demod_data;
    logic [1:0] hard_bits;
    logic       amp_on;
  } radio_t;

  // State of the selector, all but the lock history
  typedef struct packed {
    logic [5:0] sel;
    logic [4:0] status;
    logic [4:0] mask;
    logic [3:0] preamble_quality_threshold;
    logic [1:0] cca;
    logic       rx_ovf_hold;
    logic       tx_unf_hold;
    logic       frame_hold;
    logic       crc_pkt_hold;
    logic       crc_ok_hold;
    logic       ser_clk_d;
    logic       ser_data_hold;
    logic       pin;
    logic       irq;
    logic [31:0] prdata;
    logic       pready;
    logic       pslverr;
  } sel_state_t;
endpackage

/* hdl/sync2.sv */
`timescale 1ns/1ns
// Two flip-flop synchroniser for a bundle of pin levels
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,    // Clock
  input  wire logic         rst_b,  // Async reset, low
  input  wire logic [W-1:0] d,      // Asynchronous levels
  output logic      [W-1:0] q       // Synchronised levels
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // sync2

/* hdl/status_output_pin_selector.sv */
`timescale 1ns/1ns
`include "pin_select_defs.svh"

module status_output_pin_selector (
  input  wire logic                  CLK,          // 50 MHz clock
  input  wire logic                  RST_B,        // Async reset, low
  input  wire logic                  PSEL,         // APB select
  input  wire logic                  PENABLE,      // APB access phase
  input  wire logic                  PWRITE,       // APB write
  input  wire logic [11:0]           PADDR,        // APB byte address
  input  wire logic [31:0]           PWDATA,       // APB write data
  output logic      [31:0]           PRDATA,       // APB read data
  output logic                       PREADY,       // APB ready
  output logic                       PSLVERR,      // APB error
  input  wire pin_select_pkg::radio_t RADIO,       // Radio status levels
  output logic                       GENERAL_OUTPUT_PIN, // Selected signal
  output logic                       IRQ           // Level interrupt
);

  pin_select_pkg::radio_t     rad;
  pin_select_pkg::sel_state_t st_r;
  pin_select_pkg::sel_state_t st_nxt;
  logic                       acc;
  logic                       wr;
  logic                       rd_ok;
  logic [4:0]                 ev;
  logic                       lock_d_r;
  logic                       pin_val;
  logic                       clr_chan;

  // All radio levels cross into this domain
  sync2 #(.W($bits(pin_select_pkg::radio_t))) u_sync (
    .clk   (CLK),
    .rst_b (RST_B),
    .d     (RADIO),
    .q     (rad)
  );

  // Lock history for the lock-change event
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      lock_d_r <= 1'b0;
    end else begin
      lock_d_r <= rad.lock;
    end
  end

  // Bus access decode
  assign acc = PSEL && PENABLE && !st_r.pready;
  assign wr  = PSEL && PENABLE && PWRITE && st_r.pready; // Write lands on the completing edge

  // Clear-channel per mode: 0 always, 1 rssi, 2 not receiving, 3 both
  always_comb begin
    case (st_r.cca)
      2'h0:    clr_chan = 1'b1;
      2'h1:    clr_chan = rad.rssi_below;
      2'h2:    clr_chan = !rad.channel_busy_rx;
      2'h3:    clr_chan = rad.rssi_below && !rad.channel_busy_rx;
      default: clr_chan = 1'b0;
    endcase
  end

  // Next state of the whole selector
  always_comb begin
    st_nxt = st_r;
    rd_ok  = 1'b1;

    if (rad.rx_overflow) begin
      st_nxt.rx_ovf_hold = 1'b1;
    end else if (rad.rx_flush) begin
      st_nxt.rx_ovf_hold = 1'b0;
    end

    if (rad.tx_underflow) begin
      st_nxt.tx_unf_hold = 1'b1;
    end else if (rad.tx_flush) begin
      st_nxt.tx_unf_hold = 1'b0;
    end

    if (rad.pkt_end || (rad.tx_mode ? rad.tx_underflow : (rad.addr_fail || rad.rx_overflow))) begin
      st_nxt.frame_hold = 1'b0;
    end else if (rad.sync_seen) begin
      st_nxt.frame_hold = 1'b1;
    end

    if (rad.crc_done && rad.crc_match) begin
      st_nxt.crc_pkt_hold = 1'b1;
    end else if (rad.rx_first_read) begin
      st_nxt.crc_pkt_hold = 1'b0;
    end

    // last compare result, cleared on receive entry
    if (rad.rx_enter) begin
      st_nxt.crc_ok_hold = 1'b0;
    end else if (rad.crc_done) begin
      st_nxt.crc_ok_hold = rad.crc_match;
    end

    // data retimed at falling serial clock edge
    st_nxt.ser_clk_d = rad.ser_clk;
    if (st_r.ser_clk_d && !rad.ser_clk) begin
      st_nxt.ser_data_hold = rad.ser_data;
    end

    // Pin selection, registered
    st_nxt.pin = pin_val;

    // Sticky events, set wins over write-one clear
    ev = '0;
    ev[`EV_RXOVF]   = rad.rx_overflow;
    ev[`EV_TXUNF]   = rad.tx_underflow;
    ev[`EV_SYNC]    = rad.sync_seen;
    ev[`EV_CRCGOOD] = rad.crc_done && rad.crc_match;
    ev[`EV_LOCK]    = rad.lock ^ lock_d_r;
    if (wr && PADDR == `OFS_STATUS) begin
      st_nxt.status = st_r.status & ~PWDATA[4:0];
    end
    st_nxt.status = st_nxt.status | ev;

    // Address decode in the access cycle, live word is read only
    if (acc) begin
      case (PADDR)
        `OFS_SEL, `OFS_STATUS, `OFS_MASK, `OFS_PQT, `OFS_CCA: rd_ok = 1'b1;
        `OFS_LIVE: rd_ok = !PWRITE;
        default:   rd_ok = 1'b0;
      endcase
    end

    // Register writes, taken with the ready answer
    if (wr) begin
      case (PADDR)
        `OFS_SEL:    st_nxt.sel  = PWDATA[5:0];
        `OFS_MASK:   st_nxt.mask = PWDATA[4:0];
        `OFS_PQT:    st_nxt.preamble_quality_threshold  = PWDATA[3:0];
        `OFS_CCA:    st_nxt.cca  = PWDATA[1:0];
        default:     ;
      endcase
    end

    // Register reads
    st_nxt.prdata = '0;
    if (acc && !PWRITE) begin
      case (PADDR)
        `OFS_SEL:    st_nxt.prdata = {26'h0, st_r.sel};
        `OFS_STATUS: st_nxt.prdata = {27'h0, st_r.status};
        `OFS_MASK:   st_nxt.prdata = {27'h0, st_r.mask};
        `OFS_PQT:    st_nxt.prdata = {28'h0, st_r.preamble_quality_threshold};
        `OFS_CCA:    st_nxt.prdata = {30'h0, st_r.cca};
        `OFS_LIVE:   st_nxt.prdata = {26'h0, rad.lock, rad.amp_on, st_r.crc_ok_hold,
                                      st_r.frame_hold, st_r.tx_unf_hold, st_r.rx_ovf_hold};
        default:     rd_ok = 1'b0;
      endcase
    end

    // One wait state, ready pulses one cycle
    st_nxt.pready  = acc;
    st_nxt.pslverr = acc && !rd_ok;
    st_nxt.irq     = |(st_nxt.status & st_r.mask);
  end

  // Output multiplexer on the selection code
  always_comb begin
    case (st_r.sel)
      `SEL_RX_OVERFLOW:   pin_val = st_r.rx_ovf_hold;
      `SEL_TX_UNDERFLOW:  pin_val = st_r.tx_unf_hold;
      `SEL_PKT_FRAME:     pin_val = st_r.frame_hold;
      `SEL_CRC_PKT:       pin_val = st_r.crc_pkt_hold;
      `SEL_PREAMBLE_OK:   pin_val = rad.pq_level > st_r.preamble_quality_threshold;
      `SEL_CLEAR_CHAN:    pin_val = clr_chan;
      `SEL_LOCK:          pin_val = rad.lock;
      `SEL_SER_CLK:       pin_val = rad.ser_clk;
      `SEL_SER_SYNC_DATA: pin_val = st_r.ser_data_hold;
      `SEL_SER_ASYNC:     pin_val = rad.demod_data;
      `SEL_CARRIER:       pin_val = rad.rssi_above;
      `SEL_CRC_OK:        pin_val = st_r.crc_ok_hold;
      `SEL_HARD_BIT1:     pin_val = rad.hard_bits[1];
      `SEL_HARD_BIT0:     pin_val = rad.hard_bits[0];
      `SEL_AMP_POWER:     pin_val = rad.amp_on;
      default:            pin_val = 1'b0;
    endcase
  end

  // State register
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_r      <= '0;
      st_r.sel  <= `SEL_RST;
      st_r.preamble_quality_threshold  <= `PQT_RST;
      st_r.cca  <= `CCA_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign PRDATA             = st_r.prdata;
  assign PREADY             = st_r.pready;
  assign PSLVERR            = st_r.pslverr;
  assign GENERAL_OUTPUT_PIN = st_r.pin;
  assign IRQ                = st_r.irq;

  // Assertions
  sequence s_ovf_seen;
    rad.rx_overflow && st_r.sel == `SEL_RX_OVERFLOW;
  endsequence

  a_rx_ovf_pin: assert property (@(posedge CLK) disable iff (!RST_B)
    s_ovf_seen ##1 (st_r.sel == `SEL_RX_OVERFLOW) |=> GENERAL_OUTPUT_PIN)
    else $error("overflow not shown on pin");

  a_tx_unf_hold: assert property (@(posedge CLK) disable iff (!RST_B)
    st_r.tx_unf_hold && !rad.tx_flush |=> st_r.tx_unf_hold)
    else $error("underflow indication lost before flush");

  a_frame_end: assert property (@(posedge CLK) disable iff (!RST_B)
    rad.pkt_end |=> !st_r.frame_hold)
    else $error("frame indication stays after packet end");

  a_crc_pkt_read: assert property (@(posedge CLK) disable iff (!RST_B)
    rad.rx_first_read && !rad.crc_done |=> !st_r.crc_pkt_hold)
    else $error("good packet not cleared by first read");

  a_pq_thresh: assert property (@(posedge CLK) disable iff (!RST_B)
    st_r.sel == `SEL_PREAMBLE_OK && $stable(st_r.sel) |=> GENERAL_OUTPUT_PIN == ($past(rad.pq_level) > $past(st_r.preamble_quality_threshold)))
    else $error("preamble quality pin wrong");

  a_lock_route: assert property (@(posedge CLK) disable iff (!RST_B)
    st_r.sel == `SEL_LOCK |=> GENERAL_OUTPUT_PIN == $past(rad.lock))
    else $error("lock not routed");

  a_crc_ok_clr: assert property (@(posedge CLK) disable iff (!RST_B)
    rad.rx_enter |=> !st_r.crc_ok_hold)
    else $error("crc ok not cleared on receive entry");

  a_reserved_low: assert property (@(posedge CLK) disable iff (!RST_B)
    st_r.sel inside {[6'h00:6'h03], [6'h10:6'h15], [6'h18:6'h1a], [6'h1c:6'h3f]} |=> !GENERAL_OUTPUT_PIN)
    else $error("reserved code drives pin high");

  a_amp_route: assert property (@(posedge CLK) disable iff (!RST_B)
    st_r.sel == `SEL_AMP_POWER |=> GENERAL_OUTPUT_PIN == $past(rad.amp_on))
    else $error("amplifier flag not routed");

  sequence s_ser_fall;
    st_r.ser_clk_d && !rad.ser_clk;
  endsequence

  a_rx_ovf_flush: assert property (@(posedge CLK) disable iff (!RST_B)
    rad.rx_flush && !rad.rx_overflow |=> !st_r.rx_ovf_hold)
    else $error("overflow indication stays after flush");

  a_tx_unf_set: assert property (@(posedge CLK) disable iff (!RST_B)
    rad.tx_underflow |=> st_r.tx_unf_hold)
    else $error("underflow indication not set");

  a_frame_start: assert property (@(posedge CLK) disable iff (!RST_B)
    rad.sync_seen && !rad.pkt_end && !(rad.tx_mode ? rad.tx_underflow : (rad.addr_fail || rad.rx_overflow))
    |=> st_r.frame_hold)
    else $error("frame indication not set on sync word");

  a_frame_abort_rx: assert property (@(posedge CLK) disable iff (!RST_B)
    !rad.tx_mode && (rad.addr_fail || rad.rx_overflow) |=> !st_r.frame_hold)
    else $error("frame indication stays after receive abort");

  a_frame_abort_tx: assert property (@(posedge CLK) disable iff (!RST_B)
    rad.tx_mode && rad.tx_underflow |=> !st_r.frame_hold)
    else $error("frame indication stays after transmit underflow");

  a_crc_pkt_set: assert property (@(posedge CLK) disable iff (!RST_B)
    rad.crc_done && rad.crc_match |=> st_r.crc_pkt_hold)
    else $error("good packet not indicated");

  a_cca_rssi: assert property (@(posedge CLK) disable iff (!RST_B)
    st_r.sel == `SEL_CLEAR_CHAN && st_r.cca == 2'h1 |=> GENERAL_OUTPUT_PIN == $past(rad.rssi_below))
    else $error("clear channel pin wrong");

  a_ser_clk_route: assert property (@(posedge CLK) disable iff (!RST_B)
    st_r.sel == `SEL_SER_CLK |=> GENERAL_OUTPUT_PIN == $past(rad.ser_clk))
    else $error("serial clock not routed");

  a_sync_data_take: assert property (@(posedge CLK) disable iff (!RST_B)
    s_ser_fall |=> st_r.ser_data_hold == $past(rad.ser_data))
    else $error("serial data not taken at falling clock");

  a_sync_data_hold: assert property (@(posedge CLK) disable iff (!RST_B)
    !(st_r.ser_clk_d && !rad.ser_clk) |=> $stable(st_r.ser_data_hold))
    else $error("serial data changed away from falling clock");

  a_async_route: assert property (@(posedge CLK) disable iff (!RST_B)
    st_r.sel == `SEL_SER_ASYNC |=> GENERAL_OUTPUT_PIN == $past(rad.demod_data))
    else $error("transparent data not routed");

  a_carrier_route: assert property (@(posedge CLK) disable iff (!RST_B)
    st_r.sel == `SEL_CARRIER |=> GENERAL_OUTPUT_PIN == $past(rad.rssi_above))
    else $error("carrier sense not routed");

  a_hard_bit1: assert property (@(posedge CLK) disable iff (!RST_B)
    st_r.sel == `SEL_HARD_BIT1 |=> GENERAL_OUTPUT_PIN == $past(rad.hard_bits[1]))
    else $error("hard bit one not routed");

  a_hard_bit0: assert property (@(posedge CLK) disable iff (!RST_B)
    st_r.sel == `SEL_HARD_BIT0 |=> GENERAL_OUTPUT_PIN == $past(rad.hard_bits[0]))
    else $error("hard bit zero not routed");

  a_crc_ok_take: assert property (@(posedge CLK) disable iff (!RST_B)
    rad.crc_done && !rad.rx_enter |=> st_r.crc_ok_hold == $past(rad.crc_match))
    else $error("crc result not taken");

  a_ready_pulse: assert property (@(posedge CLK) disable iff (!RST_B)
    PREADY |=> !PREADY)
    else $error("ready longer than one cycle");

  a_status_sticky: assert property (@(posedge CLK) disable iff (!RST_B)
    st_r.status[`EV_RXOVF] && !(wr && PADDR == `OFS_STATUS && PWDATA[`EV_RXOVF]) |=> st_r.status[`EV_RXOVF])
    else $error("status bit lost without clear");
endmodule // status_output_pin_selector

/* tb/host_sampler.sv */
`timescale 1ns/1ns
// Host side: shifts the output pin in on each rising serial clock while listen is high
module host_sampler (
  input  wire logic       clk,     // Bench clock
  input  wire logic       rst_b,   // Async reset, low
  input  wire logic       listen,  // Host is taking bits
  input  wire logic       ser_clk, // Serial bit clock
  input  wire logic       pin,     // Output pin
  output logic      [7:0] bits_r,  // Bits taken, first in MSB
  output logic      [3:0] count_r  // Number of bits taken
);
  logic ser_clk_r; // Last clock level

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ser_clk_r <= 1'b0;
      bits_r    <= 8'h00;
      count_r   <= 4'h0;
    end else begin
      ser_clk_r <= ser_clk;
      if (listen && ser_clk && !ser_clk_r) begin
        bits_r  <= {bits_r[6:0], pin};
        count_r <= count_r + 4'h1;
      end
    end
  end
endmodule // host_sampler

/* tb/testbench.sv */
`timescale 1ns/1ns
`include "pin_select_defs.svh"
// Self-checking bench for the output pin selector
module testbench;
  typedef pin_select_pkg::radio_t rad_t;
  localparam rad_t m_ovf = '{rx_overflow: 1'b1, default: '0};
  localparam rad_t m_unf = '{tx_underflow: 1'b1, default: '0};
  localparam rad_t m_syn = '{sync_seen: 1'b1, default: '0};
  localparam rad_t m_rfl = '{rx_flush: 1'b1, default: '0};
  localparam rad_t m_tfl = '{tx_flush: 1'b1, default: '0};
  localparam rad_t m_end = '{pkt_end: 1'b1, default: '0};
  localparam rad_t m_adr = '{addr_fail: 1'b1, default: '0};
  localparam rad_t m_txu = '{tx_mode: 1'b1, tx_underflow: 1'b1, default: '0};
  localparam rad_t m_crc = '{crc_done: 1'b1, crc_match: 1'b1, default: '0};
  localparam rad_t m_frd = '{rx_first_read: 1'b1, default: '0};
  localparam rad_t m_dn  = '{crc_done: 1'b1, default: '0};
  localparam rad_t m_ent = '{rx_enter: 1'b1, default: '0};
  localparam rad_t m_lck = '{lock: 1'b1, default: '0};
  localparam rad_t m_sck = '{ser_clk: 1'b1, default: '0};
  localparam rad_t m_dm  = '{demod_data: 1'b1, default: '0};
  localparam rad_t m_ca  = '{rssi_above: 1'b1, default: '0};
  localparam rad_t m_h1  = '{hard_bits: 2'b10, default: '0};
  localparam rad_t m_h0  = '{hard_bits: 2'b01, default: '0};
  localparam rad_t m_amp = '{amp_on: 1'b1, default: '0};
  localparam rad_t m_all = '1;
  logic        clk = 1'b0;     // 50 MHz clock
  logic        rst_b = 1'b0;   // Reset, low
  logic        psel = 1'b0;    // APB select
  logic        penable = 1'b0; // APB access
  logic        pwrite = 1'b0;  // APB write
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  rad_t        rad = '0;       // Radio levels
  logic        listen = 1'b0;  // Host taking bits
  logic [31:0] prdata;
  logic        pready, pslverr, pin, irq;
  logic [7:0]  host_bits;
  logic [3:0]  host_count;
  int          n_fail = 0;
  int          check_count = 0;

  always #10 clk = ~clk;

  status_output_pin_selector i_dut (
    .CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .RADIO(rad), .GENERAL_OUTPUT_PIN(pin), .IRQ(irq));

  host_sampler i_host (
    .clk(clk), .rst_b(rst_b), .listen(listen), .ser_clk(rad.ser_clk), .pin(pin),
    .bits_r(host_bits), .count_r(host_count));

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer, waits for the ready answer
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (n == 40) begin
      $display("ERROR at %0t: no ready answer", $time);
      n_fail++;
      give_verdict();
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask

  task automatic pulse(input rad_t m);
    rad <= rad | m;
    cyc(2);
    rad <= rad & ~m;
    cyc(6);
  endtask

  task automatic t_regs();
    rd(`OFS_SEL, 32'h0, 1'b0);
    rd(`OFS_PQT, 32'h0, 1'b0);
    rd(`OFS_CCA, 32'h0, 1'b0);
    rd(12'h020, 32'h0, 1'b1);
    wr(`OFS_SEL, 32'hffffffff);
    rd(`OFS_SEL, 32'h3f, 1'b0);
    $display("test regs done");
  endtask

  // Latched event codes: set, hold, then clear
  task automatic t_latch();
    logic [5:0] lc [9] = '{6'h04, 6'h05, 6'h06, 6'h06, 6'h06, 6'h06, 6'h07, 6'h0f, 6'h0f};
    rad_t       ls [9] = '{m_ovf, m_unf, m_syn, m_syn, m_syn, m_syn, m_crc, m_crc, m_crc};
    rad_t       lr [9] = '{m_rfl, m_tfl, m_end, m_adr, m_txu, m_ovf, m_frd, m_dn, m_ent};
    for (int i = 0; i < 9; i++) begin
      pulse(lr[i]);
      wr(`OFS_SEL, {26'h0, lc[i]});
      cyc(6);
      chk(pin, 1'b0);
      pulse(ls[i]);
      cyc(8);
      chk(pin, 1'b1);
      pulse(lr[i]);
      chk(pin, 1'b0);
    end
    $display("test latch done");
  endtask

  // Direct codes, plus undefined codes held low
  task automatic t_pass();
    logic [5:0]  pc [12] = '{6'h0a, 6'h0b, 6'h0d, 6'h0e, 6'h16, 6'h16, 6'h17, 6'h17, 6'h1b, 6'h00, 6'h1c, 6'h3f};
    rad_t        pm [12] = '{m_lck, m_sck, m_dm, m_ca, m_h1, m_h0, m_h0, m_h1, m_amp, m_all, m_all, m_all};
    logic [11:0] pe = 12'hfa8;
    for (int i = 0; i < 12; i++) begin
      wr(`OFS_SEL, {26'h0, pc[i]});
      cyc(6);
      chk(pin, 1'b0);
      rad <= pm[i];
      cyc(6);
      chk(pin, pe[11-i]);
      rad <= '0;
      cyc(6);
    end
    $display("test pass done");
  endtask

  task automatic t_cca();
    logic x;
    wr(`OFS_SEL, 32'h09);
    for (int md = 0; md < 4; md++) begin
      wr(`OFS_CCA, md);
      for (int k = 0; k < 4; k++) begin
        rad.rssi_below      <= k[0];
        rad.channel_busy_rx <= k[1];
        cyc(6);
        x = (md[0] ? k[0] : 1'b1) & (md[1] ? !k[1] : 1'b1);
        chk(pin, x);
      end
    end
    rad <= '0;
    $display("test cca done");
  endtask

  task automatic t_pq();
    wr(`OFS_PQT, 32'h7);
    wr(`OFS_SEL, 32'h08);
    for (int lv = 0; lv < 16; lv++) begin
      rad.pq_level <= lv[3:0];
      cyc(6);
      chk(pin, lv > 7);
    end
    rad <= '0;
    $display("test preamble done");
  endtask

  task automatic t_serial();
    logic [7:0] dat;
    dat = 8'ha5;
    wr(`OFS_SEL, 32'h0c);
    rad.ser_clk <= 1'b1;
    cyc(4);
    listen <= 1'b1;
    for (int b = 7; b >= 0; b--) begin
      rad.ser_clk  <= 1'b0;
      rad.ser_data <= dat[b];
      cyc(8);
      rad.ser_clk  <= 1'b1;
      cyc(8);
    end
    listen <= 1'b0;
    chk(host_bits, dat);
    chk(host_count, 4'h8);
    $display("test serial done");
  endtask

  task automatic t_irq();
    pulse(m_rfl | m_tfl);
    wr(`OFS_STATUS, 32'h1f);
    wr(`OFS_MASK, 32'h0);
    rd(`OFS_STATUS, 32'h0, 1'b0);
    pulse(m_ovf);
    rd(`OFS_STATUS, 32'h1, 1'b0);
    wr(`OFS_LIVE, 32'h0);
    rd(`OFS_LIVE, 32'h1, 1'b0);
    chk(irq, 1'b0);
    wr(`OFS_MASK, 32'h1);
    cyc(2);
    chk(irq, 1'b1);
    wr(`OFS_MASK, 32'h2);
    cyc(2);
    chk(irq, 1'b0);
    wr(`OFS_MASK, 32'h1);
    wr(`OFS_STATUS, 32'h1);
    cyc(2);
    chk(irq, 1'b0);
    rd(`OFS_STATUS, 32'h0, 1'b0);
    pulse(m_unf | m_syn | m_crc | m_lck);
    rd(`OFS_STATUS, 32'h1e, 1'b0);
    $display("test irq done");
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    cyc(12);
    rst_b <= 1'b1;
    t_regs();
    t_latch();
    t_pass();
    t_cca();
    t_pq();
    t_serial();
    t_irq();
    give_verdict();
  end

  // Watchdog against a hang
  initial begin
    cyc(20000);
    n_fail++;
    give_verdict();
  end
endmodule // testbench
